/* File: capture_pkg.sv */
// register map, field positions and encodings for the input capture block
package capture_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] compare_a_index = 8'hAB;
  localparam logic [7:0] control_b_index = 8'hAC;
  localparam logic [7:0] control_a_index = 8'hAA;
  localparam logic [7:0] status_index = 8'hAD;
  localparam logic [7:0] fifo_b_index = 8'hAE;
  // capture A control fields
  localparam int arm_bit = 0;
  localparam int single_pass_bit = 1;
  localparam int edge0_lsb = 2;
  localparam int edge1_lsb = 4;
  localparam int source_bit = 6;
  // capture B control fields
  localparam int b1_words_lsb = 13;
  localparam int b0_words_lsb = 10;
  localparam int watermark_lsb = 8;
  // reset values
  localparam logic [15:0] control_a_reset = 16'h0000;
  localparam logic [15:0] control_b_reset = 16'h0000;
  localparam logic [7:0] compare_reset = 8'h00;
  // edge select encodings
  localparam logic [1:0] edge_off = 2'h0;
  localparam logic [1:0] edge_fall = 2'h1;
  localparam logic [1:0] edge_rise = 2'h2;
  localparam logic [1:0] edge_any = 2'h3;
  typedef enum logic [1:0] {
    seq_idle = 2'b00,
    seq_circuit0 = 2'b01,
    seq_circuit1 = 2'b10
  } seq_state_t;
endpackage : capture_pkg

/* File: input_capture_arm_sequencer.sv */
// input A capture arming sequencer with edge counter and capture B counts
//
// Functional notes
// - free run, both enabled: circuit 0 first, then 1
// - free run: circuit 1 captures, re-arm circuit 0
// - free run single circuit: captures repeat forever
// - single pass, both: circuit 0 first, then 1
// - single pass: after circuit 1, clear arm
// - single pass single circuit: one capture, clear arm
// - writing arm bit 1 starts capture
// - clearing arm stops capture at once
// - hardware clears arm only in single pass
// - armed capture follows per-circuit edge selects
// - compare upper byte reads edge count, read-only
// - compare lower byte is writable compare value
// - capture B1 word count field read-only
// - capture B0 word count field read-only
// - two-bit shared capture B watermark field
// - B flag only when words exceed watermark
// - source select uses edge counter compare output
// - edge codes: off, falling, rising, any
`timescale 1ns/1ns
module input_capture_arm_sequencer #(
  parameter int count_width = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture pins, asynchronous
  input wire logic capture_input_a,
  input wire logic capture_input_b,
  // capture events
  output logic capture0_event,
  output logic capture1_event,
  output logic armed0,
  output logic armed1,
  output logic edge_compare_match,
  output logic capture_b0_flag,
  output logic capture_b1_flag
);
  localparam logic [11:0] addr_ctrl_a =
    {2'h0, capture_pkg::control_a_index, 2'h0};
  localparam logic [11:0] addr_cmp_a =
    {2'h0, capture_pkg::compare_a_index, 2'h0};
  localparam logic [11:0] addr_ctrl_b =
    {2'h0, capture_pkg::control_b_index, 2'h0};
  localparam logic [11:0] addr_status =
    {2'h0, capture_pkg::status_index, 2'h0};
  localparam logic [11:0] addr_fifo_b =
    {2'h0, capture_pkg::fifo_b_index, 2'h0};

  logic [15:0] capture_a_control;
  logic [count_width-1:0] input_a_edge_compare;
  logic [count_width-1:0] input_a_edge_count;
  logic [1:0] capture_b_watermark;
  logic capture_b0_full;
  logic capture_b1_full;
  logic b_toggle;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic seen_match;
  capture_pkg::seq_state_t state;
  capture_pkg::seq_state_t next_state;
  logic [31:0] read_word;

  wire logic access = psel && penable;
  wire logic wr = access && pwrite;
  wire logic rd_access = access && !pwrite;
  wire logic capture_arm_a = capture_a_control[capture_pkg::arm_bit];
  wire logic single_pass_select_a =
    capture_a_control[capture_pkg::single_pass_bit];
  wire logic [1:0] edge_select_a_circuit0 =
    capture_a_control[capture_pkg::edge0_lsb +: 2];
  wire logic [1:0] edge_select_a_circuit1 =
    capture_a_control[capture_pkg::edge1_lsb +: 2];
  wire logic source_counter = capture_a_control[capture_pkg::source_bit];
  wire logic en0 = edge_select_a_circuit0 != capture_pkg::edge_off;
  wire logic en1 = edge_select_a_circuit1 != capture_pkg::edge_off;

  // two flip-flop synchronisers; third stage is the edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {sync_a[1:0], capture_input_a};
      sync_b <= {sync_b[1:0], capture_input_b};
    end
  end

  wire logic rise_a = sync_a[1] && !sync_a[2];
  wire logic fall_a = !sync_a[1] && sync_a[2];
  wire logic match_now = input_a_edge_count == input_a_edge_compare;

  // edge counter runs only with counter source; held at zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_a_edge_count <= '0;
    end else if (!source_counter) begin
      input_a_edge_count <= '0;
    end else if (rise_a || fall_a) begin
      input_a_edge_count <= input_a_edge_count + 1'b1;
    end
  end

  // counter output edge: a new compare match, one pulse per arrival
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_match <= 1'b0;
    end else begin
      seen_match <= source_counter && match_now;
    end
  end

  wire logic counter_edge = source_counter && match_now && !seen_match;

  function automatic logic edge_hit(input logic [1:0] sel);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      capture_pkg::edge_off: hit = 1'b0;
      capture_pkg::edge_fall: hit = fall_a;
      capture_pkg::edge_rise: hit = rise_a;
      capture_pkg::edge_any: hit = rise_a || fall_a;
    endcase
    return hit;
  endfunction : edge_hit

  // with counter source the selects only enable the circuits
  wire logic hit0 = source_counter ? (en0 && counter_edge) :
                    edge_hit(edge_select_a_circuit0);
  wire logic hit1 = source_counter ? (en1 && counter_edge) :
                    edge_hit(edge_select_a_circuit1);
  wire logic cap0 = capture_arm_a &&
    state == capture_pkg::seq_circuit0 && hit0;
  wire logic cap1 = capture_arm_a &&
    state == capture_pkg::seq_circuit1 && hit1;
  wire logic single_done = single_pass_select_a &&
    ((cap0 && !en1) || cap1);

  always_comb begin
    next_state = state;
    unique case (state)
      capture_pkg::seq_idle: begin
        if (capture_arm_a) begin
          next_state = en0 ? capture_pkg::seq_circuit0
                     : en1 ? capture_pkg::seq_circuit1
                     : capture_pkg::seq_idle;
        end
      end
      capture_pkg::seq_circuit0: begin
        if (cap0) begin
          if (single_done) begin
            next_state = capture_pkg::seq_idle;
          end else if (en1) begin
            next_state = capture_pkg::seq_circuit1;
          end
        end else if (!en0) begin
          next_state = capture_pkg::seq_idle;
        end
      end
      capture_pkg::seq_circuit1: begin
        if (cap1) begin
          if (single_done) begin
            next_state = capture_pkg::seq_idle;
          end else if (en0) begin
            next_state = capture_pkg::seq_circuit0;
          end
        end else if (!en1) begin
          next_state = capture_pkg::seq_idle;
        end
      end
      default: next_state = capture_pkg::seq_idle;
    endcase
    if (!capture_arm_a) begin
      next_state = capture_pkg::seq_idle;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= capture_pkg::seq_idle;
    end else begin
      state <= next_state;
    end
  end

  // control A: software write wins, hardware self-clears arm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_a_control <= capture_pkg::control_a_reset;
    end else if (wr && paddr == addr_ctrl_a) begin
      capture_a_control <= {9'h000, pwdata[6:0]};
    end else if (single_done) begin
      capture_a_control[capture_pkg::arm_bit] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_a_edge_compare <= capture_pkg::compare_reset;
    end else if (wr && paddr == addr_cmp_a) begin
      input_a_edge_compare <= pwdata[count_width-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_b_watermark <= capture_pkg::control_b_reset[9:8];
    end else if (wr && paddr == addr_ctrl_b) begin
      capture_b_watermark <= pwdata[capture_pkg::watermark_lsb +: 2];
    end
  end

  // one-entry B fifos: any B edge fills alternately, a read drains the entries it reported
  wire logic b_edge = sync_b[1] != sync_b[2];
  wire logic b_drain = rd_access && paddr == addr_fifo_b;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_b0_full <= 1'b0;
      capture_b1_full <= 1'b0;
      b_toggle <= 1'b0;
    end else begin
      // a fill in the drain cycle wins so no capture is lost
      // a drain clears only entries that the latched read reported
      capture_b0_full <= (b_edge && !b_toggle) ||
                         (capture_b0_full && !(b_drain && prdata[0]));
      capture_b1_full <= (b_edge && b_toggle) ||
                         (capture_b1_full && !(b_drain && prdata[1]));
      if (b_edge) begin
        b_toggle <= !b_toggle;
      end
    end
  end

  wire logic [2:0] capture_b0_fifo_words = {2'h0, capture_b0_full};
  wire logic [2:0] capture_b1_fifo_words = {2'h0, capture_b1_full};

  always_comb begin
    read_word = 32'h0000_0000;
    unique case (paddr)
      addr_ctrl_a: read_word = {16'h0000, capture_a_control};
      addr_cmp_a: read_word = {16'h0000, input_a_edge_count,
                               input_a_edge_compare};
      addr_ctrl_b: read_word = {16'h0000, capture_b1_fifo_words,
                                capture_b0_fifo_words,
                                capture_b_watermark, 8'h00};
      addr_status: read_word = {26'h0000000, capture_b1_flag,
                                capture_b0_flag, edge_compare_match,
                                armed1, armed0, capture_arm_a};
      addr_fifo_b: read_word = {30'h00000000, capture_b1_full,
                                capture_b0_full};
      default: read_word = 32'h0000_0000;
    endcase
  end

  // read data latched in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= read_word;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access && paddr != addr_ctrl_a && paddr != addr_cmp_a &&
    paddr != addr_ctrl_b && paddr != addr_status && paddr != addr_fifo_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture0_event <= 1'b0;
      capture1_event <= 1'b0;
      edge_compare_match <= 1'b0;
    end else begin
      capture0_event <= cap0;
      capture1_event <= cap1;
      edge_compare_match <= source_counter && match_now;
    end
  end

  // flags follow the counts; one-word fifos need no sticky bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_b0_flag <= 1'b0;
      capture_b1_flag <= 1'b0;
    end else begin
      capture_b0_flag <= capture_b0_fifo_words >
                         {1'b0, capture_b_watermark};
      capture_b1_flag <= capture_b1_fifo_words >
                         {1'b0, capture_b_watermark};
    end
  end

  assign armed0 = state == capture_pkg::seq_circuit0;
  assign armed1 = state == capture_pkg::seq_circuit1;
endmodule : input_capture_arm_sequencer

/* File: input_capture_arm_sequencer_properties.sv */
// checker of arming order and register read fields
`timescale 1ns/1ns
module input_capture_arm_sequencer_checker #(
  parameter int count_width = 8
) (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // sequencer outputs
  input wire logic capture0_event,
  input wire logic capture1_event,
  input wire logic armed0,
  input wire logic armed1
);
  logic wr_a;
  logic rd_b;
  logic [5:0] ctl;
  assign wr_a = psel && penable && pwrite
    && paddr == {2'h0, capture_pkg::control_a_index, 2'h0};
  assign rd_b = psel && penable && !pwrite
    && paddr == {2'h0, capture_pkg::control_b_index, 2'h0};
  // shadow of mode bits; arm self-clear not mirrored
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ctl <= 6'h00;
    else if (wr_a) ctl <= pwdata[5:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  one_armed_a: assert property (!(armed0 && armed1))
    else $error("both circuits armed");
  first_armed_a: assert property (capture0_event |-> $past(armed0))
    else $error("circuit 0 captured unarmed");
  second_armed_a: assert property (capture1_event |-> $past(armed1))
    else $error("circuit 1 captured unarmed");
  arm_start_a: assert property (wr_a && pwdata[0] && pwdata[3:2] != 2'h0
    |-> ##[1:2] armed0) else $error("arm did not arm circuit 0");
  arm_stop_a: assert property (wr_a && !pwdata[0]
    |-> ##2 (!armed0 && !armed1 && !capture0_event && !capture1_event))
    else $error("disarm ignored");
  hand_over_a: assert property (capture0_event && ctl[5:4] != 2'h0
    && !wr_a |=> armed1) else $error("no hand over to circuit 1");
  rearm_first_a: assert property (capture1_event && !ctl[1]
    && ctl[3:2] != 2'h0 && !wr_a |=> armed0) else $error("no rearm");
  free_single_a: assert property (capture0_event && !ctl[1]
    && ctl[5:4] == 2'h0 && !wr_a |=> armed0) else $error("single stopped");
  one_shot_end_a: assert property ((capture1_event || capture0_event
    && ctl[5:4] == 2'h0) && ctl[1] && !wr_a |=> !armed0 && !armed1)
    else $error("single pass kept armed");
  word_count_a: assert property (rd_b |-> prdata[15:13] <= 3'h1
    && prdata[12:10] <= 3'h1) else $error("fifo words above depth");
endmodule : input_capture_arm_sequencer_checker
bind input_capture_arm_sequencer input_capture_arm_sequencer_checker #(
  .count_width(count_width)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .capture0_event, .capture1_event,
  .armed0, .armed1);

/* File: pin_source.sv */
// far side model: drives both capture pins
`timescale 1ns/1ns
module pin_source (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // toggle requests
  input wire logic flip_a,
  input wire logic flip_b,
  // pins
  output logic pin_a,
  output logic pin_b
);
  // pins idle low; edges only when asked
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) pin_a <= 1'b0;
    else pin_a <= pin_a ^ flip_a;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) pin_b <= 1'b0;
    else pin_b <= pin_b ^ flip_b;
endmodule : pin_source

/* File: input_capture_arm_sequencer_test.sv */
// self-checking bench of the capture arm sequencer
`timescale 1ns/1ns
module input_capture_arm_sequencer_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic pin_a, pin_b, flip_a, flip_b, ev0, ev1, am0, am1, match, fb0, fb1;
  int num_errors = 0, n_compared = 0, seed = 5, c0, c1, k;
  input_capture_arm_sequencer u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .capture_input_a(pin_a), .capture_input_b(pin_b),
    .capture0_event(ev0), .capture1_event(ev1), .armed0(am0),
    .armed1(am1), .edge_compare_match(match), .capture_b0_flag(fb0),
    .capture_b1_flag(fb1));
  pin_source u_pins (.pclk, .presetn, .flip_a, .flip_b, .pin_a, .pin_b);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (ev0 === 1'b1) c0++;
    if (ev1 === 1'b1) c1++;
  end
  task check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task complete_run;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      num_errors++;
      complete_run();
    end
  endtask : apb
  task rd_chk(input string what, input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 16'h0000);
    check(what, rd, e);
  endtask : rd_chk
  // pin edges with random spacing, slow enough for the sync path
  task pulses(input int n, input logic b);
    repeat (n) begin
      @(posedge pclk);
      if (b) flip_b <= 1'b1;
      else flip_a <= 1'b1;
      @(posedge pclk);
      flip_a <= 1'b0;
      flip_b <= 1'b0;
      repeat (6 + ($random(seed) & 3)) @(posedge pclk);
    end
  endtask : pulses
  task run(input logic [15:0] ctl, input int n, e0, e1);
    c0 = 0;
    c1 = 0;
    apb(1'b1, capture_pkg::control_a_index, ctl);
    pulses(n, 1'b0);
    check("captures 0", c0, e0);
    check("captures 1", c1, e1);
  endtask : run
  function automatic int expc(input logic [1:0] code, input int n);
    return code == 2'h3 ? n : (code == 2'h0 ? 0 : n / 2);
  endfunction : expc
  initial begin
    {presetn, psel, penable, pwrite, flip_a, flip_b} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("control b", capture_pkg::control_b_index, 32'h0);
    v = $random(seed);
    apb(1'b1, capture_pkg::compare_a_index, v[15:0]);
    rd_chk("compare", capture_pkg::compare_a_index, {24'h0, v[7:0]});
    apb(1'b1, capture_pkg::control_b_index, 16'hFFFF);
    rd_chk("watermark", capture_pkg::control_b_index, 32'h300);
    apb(1'b0, 8'h10, 16'h0000);
    check("slverr", {31'h0, err}, 32'h1);
    for (k = 0; k < 4; k++)
      run(16'h0001 | 16'(k << 2), 4, expc(k[1:0], 4), 0);
    run(16'h003D, 4, 2, 2);
    run(16'h003F, 4, 1, 1);
    check("armed", {30'h0, am1, am0}, 32'h0);
    rd_chk("status", capture_pkg::status_index, 32'h0);
    run(16'h000B, 4, 1, 0);
    run(16'h0033, 4, 0, 1);
    run(16'h003D, 2, 1, 1);
    check("armed", {30'h0, am1, am0}, 32'h1);
    run(16'h0000, 2, 0, 0);
    apb(1'b1, capture_pkg::compare_a_index, 16'h0004);
    run(16'h004D, 4, 1, 0);
    rd_chk("edge count", capture_pkg::compare_a_index, 32'h404);
    check("match", {31'h0, match}, 32'h1);
    pulses(2, 1'b1);
    rd_chk("words", capture_pkg::control_b_index, 32'h2700);
    check("flags", {30'h0, fb1, fb0}, 32'h0);
    apb(1'b1, capture_pkg::control_b_index, 16'h0000);
    @(posedge pclk);
    @(posedge pclk);
    check("flags", {30'h0, fb1, fb0}, 32'h3);
    rd_chk("drain", capture_pkg::fifo_b_index, 32'h3);
    rd_chk("words", capture_pkg::control_b_index, 32'h0);
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
endmodule : input_capture_arm_sequencer_test
